// ==== rph_pkg.sv ====
// constants and state types for the radio packet handler
`default_nettype none
package rph_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW = 6;
    localparam int LEN_W = 11;
    localparam int CNT_W = 16;
    localparam int SYNC_W = 16;
    localparam int CRC_W = 16;
    localparam int CLK_HZ = 200_000_000;
    localparam int BIT_RATE_HZ = 250_000;
    // clock cycles per chip period, rounded down
    localparam int BIT_DIV = CLK_HZ / BIT_RATE_HZ;
    localparam logic [CRC_W-1:0] CRC_SEED = 16'h1d0f;
    localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
    localparam logic [8:0] WHITE_SEED = 9'h1ff;
    localparam logic [7:0] PRE_BYTE = 8'haa;
    localparam logic [1:0] MODE_STBY = 2'h0;
    localparam logic [1:0] MODE_TX = 2'h1;
    localparam logic [1:0] MODE_RX = 2'h2;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hf;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_PRE = 3'h1,
        TX_SYNC = 3'h3,
        TX_LOAD = 3'h2,
        TX_PAY = 3'h6,
        TX_CRC = 3'h7,
        TX_DONE = 3'h5
    } rph_tx_state_t;
    typedef enum logic [1:0] {
        RX_HUNT = 2'h0,
        RX_PAY = 2'h1,
        RX_CRC = 2'h3,
        RX_DONE = 2'h2
    } rph_rx_state_t;
endpackage : rph_pkg
`default_nettype wire

// ==== rph_crc16.sv ====
// bit-serial checksum generator, msb first
`default_nettype none
module rph_crc16 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic din,
    output logic [rph_pkg::CRC_W-1:0] crc_reg
);
    import rph_pkg::*;
    logic fb;
    assign fb = din ^ crc_reg[CRC_W-1];
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            crc_reg <= CRC_SEED;
        end else if (step) begin
            crc_reg <= {crc_reg[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
        end
    end
    crc_seed_a: assert property (@(posedge clk) disable iff (!rst_n)
        clear |=> crc_reg == CRC_SEED) else $error("checksum not seeded");
endmodule : rph_crc16
`default_nettype wire

// ==== rph_packet_handler.sv ====
// packet handler: byte queue, tx framer and rx deframer
// Function
// [R1] format bit one selects length-byte framing
// [R2] first byte is payload length, max 255
// [R3] host gives at least two bytes
// [R4] format zero, length zero: unlimited packets
// [R5] no sync: no filtering, fill rule governs
// [R6] unlimited: tx checksum only, no rx flags
// [R7] tx adds preamble, sync, checksum, coding
// [R8] before start send preamble or constant
// [R9] launch rule one: first byte starts
// [R10] launch rule zero: threshold plus one bytes
// [R11] condition already met starts at once
// [R12] rx strips preamble, sync; keeps payload
// [R13] fixed rx counts the length setting
// [R14] variable rx loads length, drops oversize
// [R15] address mismatch stops reception
// [R16] checksum enabled: checked, pass flagged
// [R17] frame done raises event pin zero
// [R18] bad checksum clears queue unless kept
// [R19] queue readable in sleep or standby
// [R20] host refills large tx on flags
// [R21] tx done after last bit sent
// [R22] host drains large rx on flags
// [R23] format zero, length nonzero: fixed
// [R24] manchester: one is 10, zero 01
// [R25] counter decrements per byte, ends at zero
`default_nettype none
module rph_packet_handler #(
    parameter int unsigned BIT_DIV = rph_pkg::BIT_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic frame_format_select,
    input wire logic [rph_pkg::LEN_W-1:0] frame_length_setting,
    input wire logic transmit_launch_rule,
    input wire logic sync_word_enable,
    input wire logic [rph_pkg::SYNC_W-1:0] sync_word,
    input wire logic [rph_pkg::CNT_W-1:0] preamble_len,
    input wire logic queue_fill_rule,
    input wire logic [rph_pkg::FIFO_AW-1:0] queue_threshold_setting,
    input wire logic address_check_enable,
    input wire logic [7:0] local_node_id,
    input wire logic check_enable,
    input wire logic keep_on_bad_check,
    input wire logic manchester_enable,
    input wire logic whitening_enable,
    input wire logic fifo_wr,
    input wire logic [7:0] fifo_wdata,
    input wire logic fifo_rd,
    input wire logic rx_chip_valid,
    input wire logic rx_chip,
    output logic [7:0] fifo_rdata,
    output logic queue_empty_flag,
    output logic queue_full_flag,
    output logic queue_level_flag,
    output logic tx_bit_out,
    output logic tx_frame_done_flag,
    output logic rx_frame_done_flag,
    output logic check_passed_flag,
    output logic event_pin_zero
);
    import rph_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic mode_tx, mode_rx, unlimited, tick;
    logic [15:0] div_reg;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp_reg, rp_reg;
    logic [FIFO_AW:0] fcnt_reg, fcnt_next;
    logic f_empty, f_full, host_push, host_pop, push, pop, flush;
    logic [7:0] head;
    logic [CRC_W-1:0] crc;
    logic [8:0] lfsr_reg;
    logic crc_clear, crc_step, crc_din;
    rph_tx_state_t tx_state;
    logic [3:0] tx_bit_reg;
    logic [CNT_W-1:0] tx_cnt_reg;
    logic [7:0] tx_sh_reg;
    logic tx_half_reg, tx_first_reg, tx_tog_reg, launch_met, tx_launch;
    logic man_tx, tx_adv, tx_last, tx_pay_end, tx_dbit, tx_wbit, tx_chip;
    logic tx_flag_next;
    rph_rx_state_t rx_state;
    logic [3:0] rx_bit_reg;
    logic [CNT_W-1:0] rx_cnt_reg, rx_idx_reg;
    logic [7:0] rx_sh_reg, rx_byte;
    logic [SYNC_W-1:0] sync_sh_reg;
    logic [CRC_W-1:0] rx_crcsh_reg;
    logic rx_half_reg, rx_first_reg, rx_dc_on, rx_man, rx_wht, rx_inpay;
    logic rx_dvalid, rx_dbit, rx_bdone, rx_lenpos, rx_len_bad, rx_addr_bad;
    logic rx_push, rx_pay_end, rx_crc_end, rx_crc_ok, rx_start, rx_done_set;
    logic rx_flag_next, chk_flag_next;

    assign mode_tx = mode == MODE_TX;
    assign mode_rx = mode == MODE_RX;
    assign unlimited = !frame_format_select
        && frame_length_setting == '0; // see [R4] see [R23] see [R1]

    // chip-rate enable
    always_ff @(posedge clk) begin
        if (!rst_n || div_reg == 16'(BIT_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    assign tick = div_reg == 16'(BIT_DIV - 1);

    // byte queue; host writes in any mode but rx and reads in any mode but tx
    assign f_empty = fcnt_reg == '0;
    assign f_full = fcnt_reg == (FIFO_AW+1)'(FIFO_DEPTH);
    assign head = fifo_mem[rp_reg];
    assign host_push = fifo_wr && !mode_rx;
    assign host_pop = fifo_rd && !mode_tx; // see [R19]
    assign push = (host_push || rx_push) && !f_full;
    assign pop = (host_pop || tx_state == TX_LOAD) && !f_empty;
    assign fcnt_next = flush ? '0
        : fcnt_reg + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wp_reg] <= mode_rx ? rx_byte : fifo_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_reg + FIFO_AW'(push);
            rp_reg <= rp_reg + FIFO_AW'(pop);
        end
        fcnt_reg <= rst_n ? fcnt_next : '0;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_rdata <= '0;
            queue_empty_flag <= 1'b1;
            queue_full_flag <= 1'b0;
            queue_level_flag <= 1'b0;
        end else begin
            if (host_pop && !f_empty) begin
                fifo_rdata <= head;
            end
            queue_empty_flag <= fcnt_next == '0;
            queue_full_flag <= fcnt_next == (FIFO_AW+1)'(FIFO_DEPTH);
            queue_level_flag <= fcnt_next > {1'b0, queue_threshold_setting};
        end
    end

    // shared checksum and whitening engine; tx and rx never overlap
    assign crc_clear = tx_launch || rx_start;
    assign crc_step = (tx_adv && tx_state == TX_PAY)
        || (rx_dvalid && rx_state == RX_PAY);
    assign crc_din = mode_tx ? tx_dbit : rx_dbit;
    rph_crc16 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(crc_clear),
        .step(crc_step),
        .din(crc_din),
        .crc_reg(crc)
    );
    always_ff @(posedge clk) begin
        if (!rst_n || crc_clear) begin
            lfsr_reg <= WHITE_SEED;
        end else if ((tx_adv && (tx_state == TX_PAY || tx_state == TX_CRC))
                || rx_dvalid) begin
            lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[5], lfsr_reg[8:1]};
        end
    end

    // transmit framer
    assign launch_met = transmit_launch_rule ? !f_empty // see [R9]
        : fcnt_reg > {1'b0, queue_threshold_setting}; // see [R10]
    assign tx_launch = mode_tx && tx_state == TX_IDLE && launch_met;
    assign man_tx = manchester_enable
        && (tx_state == TX_PAY || tx_state == TX_CRC);
    assign tx_adv = tick && (!man_tx || tx_half_reg);
    assign tx_last = tx_bit_reg == ((tx_state == TX_SYNC
        || tx_state == TX_CRC) ? WORD_LAST : BYTE_LAST);
    assign tx_pay_end = unlimited ? f_empty : tx_cnt_reg == CNT_W'(1);
    assign tx_dbit = tx_state == TX_PRE ? PRE_BYTE[3'h7 - tx_bit_reg[2:0]]
        : tx_state == TX_SYNC ? sync_word[WORD_LAST - tx_bit_reg]
        : tx_state == TX_PAY ? tx_sh_reg[3'h7 - tx_bit_reg[2:0]]
        : tx_state == TX_CRC ? ~crc[WORD_LAST - tx_bit_reg] // see [R7]
        : (preamble_len == '0) && tx_tog_reg; // see [R8]
    assign tx_wbit = tx_dbit ^ (man_tx ? 1'b0
        : whitening_enable && (tx_state == TX_PAY || tx_state == TX_CRC)
        && lfsr_reg[0]);
    assign tx_chip = man_tx ? tx_wbit ^ tx_half_reg : tx_wbit; // see [R24]

    always_ff @(posedge clk) begin
        if (!rst_n || !mode_tx) begin
            tx_state <= TX_IDLE;
            tx_bit_reg <= '0;
            tx_cnt_reg <= '0;
            tx_sh_reg <= '0;
            tx_half_reg <= 1'b0;
            tx_first_reg <= 1'b0;
        end else begin
            if (tick) begin
                tx_half_reg <= man_tx && !tx_half_reg;
            end
            if (tx_adv && tx_state != TX_IDLE && tx_state != TX_LOAD) begin
                tx_bit_reg <= tx_last ? '0 : tx_bit_reg + 4'h1;
            end
            unique case (tx_state)
                TX_IDLE: if (launch_met) begin // see [R11]
                    tx_first_reg <= 1'b1;
                    tx_half_reg <= 1'b0;
                    if (preamble_len != '0) begin
                        tx_state <= TX_PRE;
                        tx_cnt_reg <= preamble_len;
                    end else begin
                        tx_cnt_reg <= CNT_W'(frame_length_setting);
                        tx_state <= sync_word_enable ? TX_SYNC : TX_LOAD;
                    end
                end
                TX_PRE: if (tx_adv && tx_last) begin
                    tx_cnt_reg <= tx_cnt_reg - CNT_W'(1);
                    if (tx_cnt_reg == CNT_W'(1)) begin
                        tx_cnt_reg <= CNT_W'(frame_length_setting);
                        tx_state <= sync_word_enable ? TX_SYNC : TX_LOAD;
                    end
                end
                TX_SYNC: if (tx_adv && tx_last) begin
                    tx_state <= TX_LOAD;
                end
                TX_LOAD: begin
                    tx_sh_reg <= f_empty ? 8'h00 : head;
                    if (tx_first_reg && frame_format_select) begin
                        tx_cnt_reg <= CNT_W'(head) + CNT_W'(1); // see [R2]
                    end
                    tx_first_reg <= 1'b0;
                    tx_state <= TX_PAY;
                end
                TX_PAY: if (tx_adv && tx_last) begin
                    tx_cnt_reg <= tx_cnt_reg - CNT_W'(1); // see [R25]
                    if (tx_pay_end) begin
                        // checksum also generated in unlimited mode
                        tx_state <= check_enable ? TX_CRC : TX_DONE; // see [R6]
                    end else begin
                        tx_state <= TX_LOAD;
                    end
                end
                TX_CRC: if (tx_adv && tx_last) begin
                    tx_state <= TX_DONE;
                end
                TX_DONE: tx_state <= TX_DONE;
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_bit_out <= 1'b0;
            tx_tog_reg <= 1'b0;
        end else if (tick) begin
            tx_bit_out <= mode_tx && tx_state != TX_DONE && tx_chip;
            tx_tog_reg <= !tx_tog_reg;
        end
    end

    // receive deframer
    assign rx_dc_on = !(unlimited && !sync_word_enable); // see [R5]
    assign rx_man = manchester_enable && rx_dc_on;
    assign rx_wht = whitening_enable && !manchester_enable && rx_dc_on;
    assign rx_inpay = rx_state == RX_PAY || rx_state == RX_CRC;
    assign rx_dvalid = rx_inpay && rx_chip_valid && (!rx_man || rx_half_reg);
    // first chip of a pair carries the bit
    assign rx_dbit = (rx_man ? rx_first_reg : rx_chip)
        ^ (rx_wht && lfsr_reg[0]);
    assign rx_byte = {rx_sh_reg[6:0], rx_dbit};
    assign rx_bdone = rx_dvalid && rx_state == RX_PAY
        && rx_bit_reg == BYTE_LAST;
    assign rx_lenpos = frame_format_select && rx_idx_reg == '0;
    assign rx_len_bad = rx_bdone && rx_lenpos
        && {3'h0, rx_byte} > frame_length_setting; // see [R14]
    assign rx_addr_bad = rx_bdone && address_check_enable && rx_dc_on
        && rx_idx_reg == CNT_W'(frame_format_select)
        && rx_byte != local_node_id; // see [R15]
    assign rx_push = mode_rx && rx_bdone && !rx_len_bad && !rx_addr_bad;
    assign rx_pay_end = rx_push && !unlimited && (rx_lenpos
        ? rx_byte == 8'h00 : rx_cnt_reg == CNT_W'(1)); // see [R13] see [R25]
    assign rx_crc_end = rx_dvalid && rx_state == RX_CRC
        && rx_bit_reg == WORD_LAST;
    assign rx_crc_ok = {rx_crcsh_reg[CRC_W-2:0], rx_dbit} == ~crc;
    assign rx_start = mode_rx && rx_state == RX_HUNT && rx_chip_valid
        && (sync_word_enable
        ? {sync_sh_reg[SYNC_W-2:0], rx_chip} == sync_word // see [R12]
        : queue_fill_rule); // see [R5]
    // a bad frame is dropped whole, including bytes already queued, save a bad-checksum frame while keep_on_bad_check is set
    assign flush = mode_rx && (rx_len_bad || rx_addr_bad
        || (rx_crc_end && !rx_crc_ok && !keep_on_bad_check)); // see [R18]
    assign rx_done_set = mode_rx && ((rx_pay_end && !check_enable)
        || (rx_crc_end && (rx_crc_ok || keep_on_bad_check))); // see [R6]

    always_ff @(posedge clk) begin
        if (!rst_n || !mode_rx) begin
            rx_state <= RX_HUNT;
            sync_sh_reg <= '0;
            rx_bit_reg <= '0;
            rx_cnt_reg <= '0;
            rx_idx_reg <= '0;
            rx_sh_reg <= '0;
            rx_crcsh_reg <= '0;
            rx_half_reg <= 1'b0;
            rx_first_reg <= 1'b0;
        end else begin
            if (rx_chip_valid) begin
                sync_sh_reg <= {sync_sh_reg[SYNC_W-2:0], rx_chip};
                rx_first_reg <= rx_chip;
                rx_half_reg <= rx_inpay && rx_man && !rx_half_reg;
            end
            unique case (rx_state)
                RX_HUNT: if (rx_start) begin
                    rx_state <= RX_PAY;
                    rx_bit_reg <= '0;
                    rx_idx_reg <= '0;
                    rx_cnt_reg <= CNT_W'(frame_length_setting); // see [R13]
                end
                RX_PAY: if (rx_dvalid) begin
                    rx_sh_reg <= rx_byte;
                    rx_bit_reg <= rx_bdone ? '0 : rx_bit_reg + 4'h1;
                    if (rx_bdone) begin
                        rx_idx_reg <= rx_idx_reg + CNT_W'(1);
                        rx_cnt_reg <= rx_lenpos ? CNT_W'(rx_byte)
                            : rx_cnt_reg - CNT_W'(1);
                        if (rx_len_bad || rx_addr_bad) begin
                            rx_state <= RX_HUNT;
                        end else if (rx_pay_end) begin
                            rx_state <= check_enable ? RX_CRC : RX_DONE;
                        end
                    end
                end
                RX_CRC: if (rx_dvalid) begin
                    rx_crcsh_reg <= {rx_crcsh_reg[CRC_W-2:0], rx_dbit};
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    if (rx_crc_end) begin
                        rx_state <= (rx_crc_ok || keep_on_bad_check)
                            ? RX_DONE : RX_HUNT;
                    end
                end
                RX_DONE: rx_state <= RX_DONE;
            endcase
        end
    end

    // status flags; a set in the clearing cycle wins, save on tx done, where leaving tx mode wins
    assign rx_flag_next = rx_done_set || (rx_frame_done_flag
        && !(host_pop && fcnt_next == '0));
    assign chk_flag_next = (rx_crc_end && rx_crc_ok && mode_rx) // see [R16]
        || (check_passed_flag && !rx_start);
    assign tx_flag_next = mode_tx && (tx_frame_done_flag
        || (tx_state == TX_DONE && tick)); // see [R21]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_frame_done_flag <= 1'b0;
            check_passed_flag <= 1'b0;
            tx_frame_done_flag <= 1'b0;
            event_pin_zero <= 1'b0;
        end else begin
            rx_frame_done_flag <= rx_flag_next;
            check_passed_flag <= chk_flag_next;
            tx_frame_done_flag <= tx_flag_next;
            event_pin_zero <= (mode_rx && rx_flag_next)
                || (mode_tx && tx_flag_next); // see [R17]
        end
    end

    sequence s_bad_check;
        rx_crc_end && !rx_crc_ok && !keep_on_bad_check && mode_rx;
    endsequence
    sequence s_queue_cleared;
        fcnt_reg == '0 ##1 !$rose(rx_frame_done_flag);
    endsequence
    hold_off_a: assert property (tx_state == TX_IDLE && mode_tx // see [R8]
        && !launch_met && $stable(mode) |=> tx_state == TX_IDLE)
        else $error("tx left idle without launch");
    idle_const_a: assert property (mode_tx && tx_state == TX_IDLE // see [R8]
        && preamble_len != '0 && tick |=> !tx_bit_out)
        else $error("idle pattern not constant zero");
    launch_go_a: assert property (tx_launch && $stable(mode) // see [R11]
        |=> tx_state != TX_IDLE) else $error("launch not taken");
    tx_done_a: assert property ($rose(tx_frame_done_flag) // see [R21]
        |-> $past(tx_state, 1) == TX_DONE) else $error("early tx done");
    unlim_flags_a: assert property (unlimited && mode_rx // see [R6]
        && $stable(unlimited) |=> !$rose(rx_frame_done_flag)
        && !$rose(check_passed_flag)) else $error("flag in unlimited rx");
    len_drop_a: assert property (rx_len_bad && mode_rx // see [R14]
        |=> rx_state == RX_HUNT && fcnt_reg == '0)
        else $error("oversize frame kept");
    addr_stop_a: assert property (rx_addr_bad && mode_rx // see [R15]
        |=> rx_state == RX_HUNT) else $error("address mismatch ignored");
    bad_check_a: assert property (s_bad_check // see [R18]
        |=> s_queue_cleared) else $error("bad frame kept");
    event_pin_a: assert property (rx_done_set // see [R17]
        |=> event_pin_zero && rx_frame_done_flag)
        else $error("frame done event missing");
    manch_pair_a: assert property (man_tx && tick && tx_half_reg // see [R24]
        |-> tx_chip != tx_bit_out) else $error("manchester pairing");
endmodule : rph_packet_handler
`default_nettype wire

// ==== rph_host_model.sv ====
// host side model: queue writes and reads on flags
`default_nettype none
module rph_host_model (
    input wire logic clk,
    input wire logic queue_empty_flag,
    input wire logic queue_full_flag,
    input wire logic [7:0] fifo_rdata,
    output logic fifo_wr,
    output logic [7:0] fifo_wdata,
    output logic fifo_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fifo_wr = 1'b0;
        fifo_wdata = 8'h00;
        fifo_rd = 1'b0;
    end
    // stalls on full so a long tx never loses a byte
    task automatic push(input logic [7:0] b);
        @(negedge clk);
        while (queue_full_flag !== 1'b0) @(negedge clk);
        fifo_wr = 1'b1;
        fifo_wdata = b;
        @(negedge clk);
        fifo_wr = 1'b0;
        // released data inverted, never a stale copy
        fifo_wdata = ~b;
    endtask : push
    // pauses while empty, as a long rx needs
    task automatic pull(output logic [7:0] b);
        @(negedge clk);
        while (queue_empty_flag !== 1'b0) @(negedge clk);
        fifo_rd = 1'b1;
        @(negedge clk);
        fifo_rd = 1'b0;
        b = fifo_rdata;
    endtask : pull
endmodule : rph_host_model
`default_nettype wire

// ==== rph_packet_handler_tb.sv ====
// self-checking bench for the radio packet handler
`default_nettype none
module rph_packet_handler_tb;
    import rph_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam logic [15:0] SYNC = 16'hc35a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode = MODE_STBY;
    logic fmt = 1'b0, launch = 1'b1, syn = 1'b1, chk = 1'b0, man = 1'b0;
    logic addr_en = 1'b0, rx_v = 1'b0, rx_c = 1'b0;
    logic keep = 1'b0;
    logic [15:0] pre = 16'h0001, crc_err = 16'h0000;
    logic [10:0] flen = 11'h000;
    logic [5:0] thr = 6'h00;
    logic wr, rd, q_emp, q_full, q_lvl, tx_bit, tx_done, rx_done, ok_f, ev0;
    logic [7:0] wdata, rdata;
    int mismatches = 0;
    int n_tests = 0;
    logic samp[$];
    logic exp[$];
    always #2.5 clk = ~clk;
    rph_packet_handler #(.BIT_DIV(DIV)) rph_packet_handler_i (
        .clk(clk), .rst_n(rst_n), .mode(mode),
        .frame_format_select(fmt), .frame_length_setting(flen),
        .transmit_launch_rule(launch), .sync_word_enable(syn),
        .sync_word(SYNC), .preamble_len(pre),
        .queue_fill_rule(1'b0), .queue_threshold_setting(thr),
        .address_check_enable(addr_en), .local_node_id(8'h42),
        .check_enable(chk), .keep_on_bad_check(keep),
        .manchester_enable(man), .whitening_enable(1'b0),
        .fifo_wr(wr), .fifo_wdata(wdata), .fifo_rd(rd),
        .rx_chip_valid(rx_v), .rx_chip(rx_c), .fifo_rdata(rdata),
        .queue_empty_flag(q_emp), .queue_full_flag(q_full),
        .queue_level_flag(q_lvl), .tx_bit_out(tx_bit),
        .tx_frame_done_flag(tx_done), .rx_frame_done_flag(rx_done),
        .check_passed_flag(ok_f), .event_pin_zero(ev0)
    );
    rph_host_model host_i (
        .clk(clk), .queue_empty_flag(q_emp), .queue_full_flag(q_full),
        .fifo_rdata(rdata), .fifo_wr(wr), .fifo_wdata(wdata),
        .fifo_rd(rd)
    );
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    // expected chips, msb first, optionally as chip pairs
    task automatic add(input logic [7:0] v, input logic enc);
        for (int i = 7; i >= 0; i--) begin
            exp.push_back(v[i]);
            if (enc)
                exp.push_back(~v[i]);
        end
    endtask : add
    // chip phase is unknown, so every sample phase is tried
    function automatic logic found();
        for (int p = 0; p < DIV; p++)
            for (int s = p; s + DIV * exp.size() <= samp.size(); s += DIV) begin
                int k;
                k = 0;
                while (k < exp.size() && samp[s + DIV * k] === exp[k]) k++;
                if (k == exp.size())
                    return 1'b1;
            end
        return 1'b0;
    endfunction : found
    task automatic tx_capture();
        samp.delete();
        for (int i = 0; i < 3000 && tx_done !== 1'b1; i++) begin
            @(negedge clk);
            samp.push_back(tx_bit);
        end
        check(tx_done === 1'b1 && ev0 === 1'b1,
            "tx done missing");
        check(found(), "tx chip stream");
        mode = MODE_STBY;
        @(negedge clk);
        check(tx_done === 1'b0, "tx done kept");
    endtask : tx_capture
    task automatic quiet(input string what);
        logic first;
        int flips;
        flips = 0;
        @(negedge clk);
        first = tx_bit;
        repeat (40) begin
            @(negedge clk);
            flips += (tx_bit !== first);
        end
        check(flips == 0, what);
    endtask : quiet
    task automatic t_tx_var();
        exp.delete();
        fmt = 1'b1;
        flen = 11'h0ff;
        launch = 1'b1;
        pre = 16'h0002;
        add(PRE_BYTE, 1'b0);
        add(PRE_BYTE, 1'b0);
        add(SYNC[15:8], 1'b0);
        add(SYNC[7:0], 1'b0);
        // length byte first, at least two bytes in all
        host_i.push(8'h02);
        host_i.push(8'h3c);
        host_i.push(8'hd1);
        add(8'h02, 1'b0);
        add(8'h3c, 1'b0);
        add(8'hd1, 1'b0);
        @(negedge clk);
        mode = MODE_TX;
        tx_capture();
        pre = 16'h0001;
        $display("test tx variable done");
    endtask : t_tx_var
    task automatic t_tx_thr();
        exp.delete();
        fmt = 1'b0;
        flen = 11'h003;
        launch = 1'b0;
        thr = 6'h02;
        man = 1'b1;
        add(PRE_BYTE, 1'b0);
        add(SYNC[15:8], 1'b0);
        add(SYNC[7:0], 1'b0);
        add(8'h96, 1'b1);
        add(8'h0f, 1'b1);
        add(8'he1, 1'b1);
        mode = MODE_TX;
        quiet("chips before any byte");
        host_i.push(8'h96);
        host_i.push(8'h0f);
        quiet("started below threshold");
        host_i.push(8'he1);
        check(q_lvl === 1'b1, "level flag missing");
        tx_capture();
        man = 1'b0;
        $display("test tx threshold done");
    endtask : t_tx_thr
    task automatic chips(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            rx_c = v[i];
            rx_v = 1'b1;
            @(negedge clk);
            rx_v = 1'b0;
            rx_c = ~v[i];
        end
    endtask : chips
    // expected checksum, sent inverted
    function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
        logic [15:0] c;
        c = CRC_SEED;
        foreach (d[i])
            for (int j = 7; j >= 0; j--)
                c = {c[14:0], 1'b0} ^ (d[i][j] ^ c[15] ? CRC_POLY : '0);
        return ~c;
    endfunction : crc_of
    task automatic rx_pkt(input logic [7:0] d[$], input logic ok);
        logic [7:0] b;
        logic [15:0] c;
        @(negedge clk);
        mode = MODE_RX;
        chips(PRE_BYTE);
        chips(SYNC[15:8]);
        chips(SYNC[7:0]);
        foreach (d[i])
            chips(d[i]);
        c = crc_of(d) ^ crc_err;
        for (int i = 0; i < 2 && chk; i++)
            chips(c[15 - 8 * i -: 8]);
        repeat (4) @(negedge clk);
        check(rx_done === ok && ev0 === ok,
            "rx done flag");
        mode = MODE_STBY;
        if (ok)
            foreach (d[i]) begin
                host_i.pull(b);
                check(b === d[i], "rx payload byte");
            end
        @(negedge clk);
        check(q_emp === 1'b1 && rx_done === 1'b0,
            "queue left over");
    endtask : rx_pkt
    task automatic t_rx();
        fmt = 1'b0;
        flen = 11'h002;
        rx_pkt('{8'h5e, 8'h71}, 1'b1);
        addr_en = 1'b1;
        rx_pkt('{8'h43, 8'h99}, 1'b0);
        rx_pkt('{8'h42, 8'h99}, 1'b1);
        addr_en = 1'b0;
        fmt = 1'b1;
        flen = 11'h003;
        rx_pkt('{8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0);
        rx_pkt('{8'h03, 8'h0a, 8'h0b, 8'h0c}, 1'b1);
        chk = 1'b1;
        rx_pkt('{8'h02, 8'h5e, 8'h71}, 1'b1);
        check(ok_f === 1'b1, "check not passed");
        crc_err = 16'h0100;
        rx_pkt('{8'h01, 8'h77}, 1'b0);
        keep = 1'b1;
        rx_pkt('{8'h01, 8'h77}, 1'b1);
        check(ok_f === 1'b0, "bad check passed");
        $display("test rx done");
    endtask : t_rx
    initial begin
        repeat (50000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(q_emp === 1'b1 && {q_full, q_lvl, tx_done} === 3'h0 &&
            {rx_done, ok_f, ev0} === 3'h0, "reset state");
        $display("test reset done");
        t_tx_var();
        t_tx_thr();
        t_rx();
        close_out();
    end
endmodule : rph_packet_handler_tb
`default_nettype wire
